// ===== src/trac_ctrl.sv
/*
 * trigger state machine, read query, averaging and open-correction format control.
 * assumes a measurement engine that takes a start pulse, honours abort and reports done with its result.
 */
// The Wishbone register port and the address map were decided locally.
// How it works
// - init command moves idle to trigger waiting
// - read query aborts measurement, enters waiting
// - read returns result of next measurement
// - result holds status, primary, secondary, extra
// - pending read blocks commands, bus trigger ignored
// - device clear releases blocked read wait
// - averaging count 1 to 256, MIN/MAX
// - acquisition time is count times base, count taken as 1 while averaging off
// - averaging applied only while enabled
// - count reads back as plain integer
// - panel count sets averaging on or off
// - open-correction format held and read back
// - continuous initiation rearms after each measurement
// - continuous on at power-up, off by reset command
`timescale 1ns/100ps
`default_nettype none
`include "trac_cfg.svh"

module trac_ctrl
	import trac_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// trigger
	input wire logic trigger_i,
	// measurement engine
	input wire logic [15:0] base_interval_i,
	input wire logic meas_done_i,
	input wire trac_result_s meas_result_i,
	output logic meas_start_o,
	output logic meas_abort_o,
	output logic [8:0] meas_avg_count_o,
	output logic [24:0] acq_cycles_o,
	output logic conductance_susceptance_format_o,
	output logic parallel_cap_conductance_format_o
);

	trac_state_s r;
	trac_state_s next_r;
	trac_acc_s acc;
	logic [7:0] raddr;
	logic [31:0] rdata;
	logic wr;
	logic cmd_wr;
	logic dclr;
	logic init;
	logic rq;
	logic rst_cmd;
	logic panel_init;
	logic bus_trig;
	logic cfg_wr;
	logic cnt_wr;
	logic trig_ok;
	logic res_rd;
	logic [8:0] cnt_val;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [24:0] acq_time(input logic [8:0] cnt, input logic [15:0] base);
		acq_time = {16'h0000, cnt} * {9'h000, base};
	endfunction

	function automatic logic [8:0] eff_count(input logic en, input logic [8:0] cnt);
		eff_count = en ? cnt : `TRAC_AVG_MIN;
	endfunction

	function automatic logic [1:0] state_code(input trac_trig_e s);
		case (s)
			TRS_IDLE: state_code = 2'h0;
			TRS_WAIT: state_code = 2'h1;
			TRS_MEAS: state_code = 2'h2;
			default: state_code = 2'h3;
		endcase
	endfunction

	// ****************************************
	// bus slave
	// ****************************************
	trac_wb_slave u_wb (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cyc_i(wb_cyc_i),
		.stb_i(wb_stb_i),
		.we_i(wb_we_i),
		.adr_i(wb_adr_i),
		.sel_i(wb_sel_i),
		.dat_i(wb_dat_i),
		.dat_o(wb_dat_o),
		.ack_o(wb_ack_o),
		.rdata_i(rdata),
		.acc_o(acc),
		.raddr_o(raddr)
	);

	// ****************************************
	// read mux
	// ****************************************
	always_comb begin
		rdata = 32'h0000_0000;
		case (raddr)
			`TRAC_OFS_CONFIG: begin
				rdata[`TRAC_CFG_CONT] = r.cont;
				rdata[`TRAC_CFG_AVG_EN] = r.avg_en;
				rdata[`TRAC_CFG_OPEN_FMT] = r.open_fmt;
			end
			`TRAC_OFS_AVG_COUNT: begin
				rdata[`TRAC_AVG_VAL_MSB:0] = r.avg_count;
			end
			`TRAC_OFS_STATUS: begin
				rdata[1:0] = state_code(r.state);
				rdata[`TRAC_ST_PENDING] = r.pending;
				rdata[`TRAC_ST_VALID] = r.res_valid;
			end
			`TRAC_OFS_RES_STAT: begin
				rdata[7:0] = r.res.status;
				rdata[9:8] = r.res.extra_kind;
				rdata[23:16] = r.res.extra;
				rdata[`TRAC_RES_VALID] = r.res_valid;
			end
			`TRAC_OFS_RES_PRI: begin
				rdata = r.res.primary;
			end
			`TRAC_OFS_RES_SEC: begin
				rdata = r.res.secondary;
			end
			default: begin
				rdata = 32'h0000_0000;
			end
		endcase
	end

	// ****************************************
	// command decode
	// ****************************************
	always_comb begin
		wr = acc.stb && acc.we;
		cmd_wr = wr && (acc.addr == `TRAC_OFS_CMD) && acc.sel[0];
		// device clear is the only command honoured while a read is pending
		dclr = cmd_wr && acc.wdata[`TRAC_CMD_DCLR];
		init = cmd_wr && !r.pending && acc.wdata[`TRAC_CMD_INIT];
		rq = cmd_wr && !r.pending && acc.wdata[`TRAC_CMD_READ] && !dclr;
		rst_cmd = cmd_wr && !r.pending && acc.wdata[`TRAC_CMD_RST];
		panel_init = cmd_wr && !r.pending && acc.wdata[`TRAC_CMD_PANEL_INIT];
		bus_trig = cmd_wr && !r.pending && acc.wdata[`TRAC_CMD_BUS_TRIG];
		cfg_wr = wr && !r.pending && (acc.addr == `TRAC_OFS_CONFIG) && acc.sel[0];
		cnt_wr = wr && !r.pending && (acc.addr == `TRAC_OFS_AVG_COUNT);
		res_rd = acc.stb && !acc.we && (acc.addr == `TRAC_OFS_RES_STAT);
		// the read query itself never triggers; trigger comes separately
		trig_ok = (r.state == TRS_WAIT) && (trigger_i || bus_trig) && !rq && !dclr;
		case (acc.wdata[`TRAC_AVG_KEY_MSB:`TRAC_AVG_KEY_LSB])
			`TRAC_AVG_KEY_MIN: cnt_val = `TRAC_AVG_MIN;
			`TRAC_AVG_KEY_MAX: cnt_val = `TRAC_AVG_MAX;
			default: cnt_val = acc.wdata[`TRAC_AVG_VAL_MSB:0];
		endcase
	end

	// ****************************************
	// control state
	// ****************************************
	always_comb begin
		next_r = r;
		next_r.start = 1'b0;
		next_r.abort = 1'b0;
		next_r.acq = acq_time(eff_count(r.avg_en, r.avg_count), base_interval_i);
		// configuration
		if (cfg_wr) begin
			next_r.cont = acc.wdata[`TRAC_CFG_CONT];
			next_r.avg_en = acc.wdata[`TRAC_CFG_AVG_EN];
			next_r.open_fmt = acc.wdata[`TRAC_CFG_OPEN_FMT];
		end
		if (cnt_wr && acc.sel[3] && acc.sel[1] && acc.sel[0]) begin
			if (cnt_val >= `TRAC_AVG_MIN && cnt_val <= `TRAC_AVG_MAX) begin
				next_r.avg_count = cnt_val;
				if (acc.wdata[`TRAC_AVG_PANEL]) begin
					next_r.avg_en = (cnt_val >= `TRAC_AVG_AUTO_ON);
				end
			end
		end
		if (rst_cmd) begin
			next_r.cont = 1'b0;
		end
		if (panel_init) begin
			next_r.cont = 1'b1;
		end
		// a result read clears valid; a completing measurement below still wins
		if (res_rd) begin
			next_r.res_valid = 1'b0;
		end
		// trigger system
		case (r.state)
			TRS_IDLE: begin
				if (init) begin
					next_r.state = TRS_WAIT;
				end
			end
			TRS_WAIT: begin
				if (trig_ok) begin
					next_r.start = 1'b1;
					next_r.state = TRS_MEAS;
				end
			end
			TRS_MEAS: begin
				if (meas_done_i) begin
					next_r.res = meas_result_i;
					next_r.res_valid = 1'b1;
					next_r.pending = 1'b0;
					next_r.state = r.cont ? TRS_WAIT : TRS_IDLE;
				end
			end
			default: begin
				next_r.state = TRS_IDLE;
			end
		endcase
		if (rq) begin
			next_r.abort = (r.state == TRS_MEAS);
			next_r.state = TRS_WAIT;
			next_r.pending = 1'b1;
			next_r.res_valid = 1'b0;
		end
		if (dclr) begin
			next_r.abort = (r.state == TRS_MEAS);
			next_r.state = TRS_IDLE;
			next_r.pending = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '0;
			r.state <= TRS_IDLE;
			r.cont <= `TRAC_RST_CONT;
			r.avg_en <= `TRAC_RST_AVG_EN;
			r.avg_count <= `TRAC_RST_AVG_COUNT;
			r.open_fmt <= `TRAC_RST_OPEN_FMT;
		end else begin
			r <= next_r;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign meas_start_o = r.start;
	assign meas_abort_o = r.abort;
	assign meas_avg_count_o = eff_count(r.avg_en, r.avg_count);
	assign acq_cycles_o = r.acq;
	assign conductance_susceptance_format_o = !r.open_fmt;
	assign parallel_cap_conductance_format_o = r.open_fmt;

	// ****************************************
	// checks
	// ****************************************
	chk_init_from_idle:
	assert property (@(posedge clk_i) disable iff (rst_i)
		(r.state == TRS_IDLE && init && !rq && !dclr) |=> r.state == TRS_WAIT)
		else $error("init did not leave idle");

	chk_read_query_wait:
	assert property (@(posedge clk_i) disable iff (rst_i)
		(rq && r.state == TRS_MEAS) |=> (r.state == TRS_WAIT && r.pending && meas_abort_o))
		else $error("read query did not abort into waiting");

	chk_read_result_ready:
	assert property (@(posedge clk_i) disable iff (rst_i)
		(r.pending && r.state == TRS_MEAS && meas_done_i && !dclr) |=> (r.res_valid && !r.pending))
		else $error("read result not delivered");

	chk_result_copy:
	assert property (@(posedge clk_i) disable iff (rst_i)
		(r.state == TRS_MEAS && meas_done_i && !dclr && !rq) |=> r.res == $past(meas_result_i))
		else $error("result fields not captured");

	chk_bus_trig_blocked:
	assert property (@(posedge clk_i) disable iff (rst_i)
		(r.pending && r.state == TRS_WAIT && !trigger_i && !dclr) |=> (r.state == TRS_WAIT && !meas_start_o))
		else $error("bus trigger ran while read pending");

	chk_dclr_release:
	assert property (@(posedge clk_i) disable iff (rst_i)
		dclr |=> (!r.pending && r.state == TRS_IDLE))
		else $error("device clear did not release");

	chk_count_in_range:
	assert property (@(posedge clk_i) disable iff (rst_i)
		r.avg_count >= `TRAC_AVG_MIN && r.avg_count <= `TRAC_AVG_MAX)
		else $error("averaging count out of range");

	chk_acq_product:
	assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) |->
		acq_cycles_o == $past({16'h0000, meas_avg_count_o}) * $past({9'h000, base_interval_i}))
		else $error("acquisition time mismatch");

	chk_avg_gate:
	assert property (@(posedge clk_i) disable iff (rst_i)
		!r.avg_en |-> meas_avg_count_o == `TRAC_AVG_MIN)
		else $error("averaging applied while off");

	chk_panel_auto:
	assert property (@(posedge clk_i) disable iff (rst_i)
		(cnt_wr && acc.wdata[`TRAC_AVG_PANEL] && &{acc.sel[3], acc.sel[1], acc.sel[0]} &&
		cnt_val >= `TRAC_AVG_MIN && cnt_val <= `TRAC_AVG_MAX) |=> r.avg_en == (r.avg_count >= `TRAC_AVG_AUTO_ON))
		else $error("panel count did not set averaging state");

	chk_fmt_hold:
	assert property (@(posedge clk_i) disable iff (rst_i)
		!cfg_wr |=> $stable(r.open_fmt))
		else $error("open format changed without write");

	chk_cont_rearm:
	assert property (@(posedge clk_i) disable iff (rst_i)
		(r.state == TRS_MEAS && meas_done_i && !rq && !dclr) |=> r.state == ($past(r.cont) ? TRS_WAIT : TRS_IDLE))
		else $error("continuous initiation not honoured");

	chk_reset_cmd_cont:
	assert property (@(posedge clk_i) disable iff (rst_i)
		(rst_cmd && !panel_init) |=> !r.cont)
		else $error("reset command left continuous on");

	chk_one_start:
	assert property (@(posedge clk_i) disable iff (rst_i)
		meas_start_o |-> (r.state == TRS_MEAS && $past(r.state) == TRS_WAIT) ##1 !meas_start_o)
		else $error("trigger started other than one measurement");

endmodule

`default_nettype wire

// ===== src/trac_cfg.svh
/*
 * offsets, field positions, reset values and limits of the trigger/read/averaging control block.
 * assumes a 32-bit classic Wishbone register bus with byte addresses in adr_i[7:0].
 */
`ifndef TRAC_CFG_SVH
`define TRAC_CFG_SVH

// ****************************************
// register offsets
// ****************************************
`define TRAC_OFS_CMD 8'h00
`define TRAC_OFS_CONFIG 8'h04
`define TRAC_OFS_AVG_COUNT 8'h08
`define TRAC_OFS_STATUS 8'h0C
`define TRAC_OFS_RES_STAT 8'h10
`define TRAC_OFS_RES_PRI 8'h14
`define TRAC_OFS_RES_SEC 8'h18

// ****************************************
// command register bits (write one to act)
// ****************************************
`define TRAC_CMD_INIT 0
`define TRAC_CMD_READ 1
`define TRAC_CMD_DCLR 2
`define TRAC_CMD_RST 3
`define TRAC_CMD_PANEL_INIT 4
`define TRAC_CMD_BUS_TRIG 5

// ****************************************
// config register bits
// ****************************************
`define TRAC_CFG_CONT 0
`define TRAC_CFG_AVG_EN 1
`define TRAC_CFG_OPEN_FMT 2

// ****************************************
// averaging count register fields
// ****************************************
`define TRAC_AVG_VAL_MSB 8
`define TRAC_AVG_KEY_LSB 9
`define TRAC_AVG_KEY_MSB 10
`define TRAC_AVG_PANEL 31
`define TRAC_AVG_KEY_NUM 2'h0
`define TRAC_AVG_KEY_MIN 2'h1
`define TRAC_AVG_KEY_MAX 2'h2
`define TRAC_AVG_MIN 9'h001
`define TRAC_AVG_MAX 9'h100
`define TRAC_AVG_AUTO_ON 9'h002

// ****************************************
// status and result fields
// ****************************************
`define TRAC_ST_PENDING 2
`define TRAC_ST_VALID 3
`define TRAC_RES_VALID 31

// ****************************************
// reset values
// ****************************************
`define TRAC_RST_CONT 1'b1
`define TRAC_RST_AVG_EN 1'b0
`define TRAC_RST_AVG_COUNT 9'h001
`define TRAC_RST_OPEN_FMT 1'b0

`endif

// ===== src/trac_pkg.sv
/*
 * types of the trigger/read/averaging control block.
 * assumes trac_cfg.svh for all numeric constants.
 */
`default_nettype none

package trac_pkg;

	// trigger system states
	typedef enum logic [1:0] {
		TRS_IDLE,
		TRS_WAIT,
		TRS_MEAS
	} trac_trig_e;

	// one measurement result from the engine
	typedef struct packed {
		logic [7:0] status;
		logic [31:0] primary;
		logic [31:0] secondary;
		logic [1:0] extra_kind;
		logic [7:0] extra;
	} trac_result_s;

	// register access handed from the bus slave, valid in the ack cycle
	typedef struct packed {
		logic stb;
		logic we;
		logic [7:0] addr;
		logic [3:0] sel;
		logic [31:0] wdata;
	} trac_acc_s;

	// bus slave state
	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} trac_wb_s;

	// control state
	typedef struct packed {
		trac_trig_e state;
		logic pending;
		logic cont;
		logic avg_en;
		logic [8:0] avg_count;
		logic open_fmt;
		trac_result_s res;
		logic res_valid;
		logic start;
		logic abort;
		logic [24:0] acq;
	} trac_state_s;

endpackage

`default_nettype wire

// ===== src/trac_wb_slave.sv
/*
 * classic Wishbone slave front end: one wait state, registered ack and read data.
 * assumes the master holds its request until it samples ack high.
 */
`timescale 1ns/100ps
`default_nettype none

module trac_wb_slave
	import trac_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// register side
	input wire logic [31:0] rdata_i,
	output trac_acc_s acc_o,
	output logic [7:0] raddr_o
);

	trac_wb_s r;
	trac_wb_s next_r;

	// ****************************************
	// handshake
	// ****************************************
	always_comb begin
		next_r = r;
		next_r.ack = cyc_i && stb_i && !r.ack;
		if (cyc_i && stb_i && !r.ack) begin
			next_r.dat = rdata_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign ack_o = r.ack;
	assign dat_o = r.dat;
	assign raddr_o = adr_i;
	// access commits at the edge where the master sees ack
	assign acc_o.stb = cyc_i && stb_i && r.ack;
	assign acc_o.we = we_i;
	assign acc_o.addr = adr_i;
	assign acc_o.sel = sel_i;
	assign acc_o.wdata = dat_i;

	chk_ack_one_cycle:
	assert property (@(posedge clk_i) disable iff (rst_i) r.ack |=> !r.ack)
		else $error("ack held longer than one cycle");

endmodule

`default_nettype wire

// ===== sim/trac_meas_engine.sv
/*
 * behavioural measurement engine facing trac_ctrl.
 * assumes the bench picks the run length and the result of each measurement.
 */
`timescale 1ns/100ps
`default_nettype none

module trac_meas_engine
	import trac_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// control from the block
	input wire logic start_i,
	input wire logic abort_i,
	// behaviour chosen by the bench
	input wire logic [7:0] delay_i,
	input wire trac_result_s result_i,
	// report to the block
	output logic done_o,
	output trac_result_s result_o
);
	logic [8:0] left;
	logic busy;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy <= 1'b0;
			left <= 9'h000;
			done_o <= 1'b0;
			result_o <= '0;
		end else begin
			done_o <= 1'b0;
			// result lines carry nothing valid outside the done cycle
			result_o <= ~result_o;
			if (abort_i) begin
				busy <= 1'b0;
			end else if (start_i) begin
				busy <= 1'b1;
				left <= {1'b0, delay_i};
			end else if (busy && left == 9'h000) begin
				busy <= 1'b0;
				done_o <= 1'b1;
				result_o <= result_i;
			end else if (busy) begin
				left <= left - 9'h001;
			end
		end
	end
endmodule

`default_nettype wire

// ===== sim/trac_ctrl_tb_top.sv
/*
 * self-checking bench of trac_ctrl with a behavioural engine.
 * assumes 125 MHz clock and the design's own assertions.
 */
`timescale 1ns/100ps
`default_nettype none
`include "trac_cfg.svh"

module trac_ctrl_tb_top
	import trac_pkg::*;
;
	logic clk_i, rst_i, cyc, stb, we, ack, trig, done, start, abort, fgb, fcpg;
	logic [7:0] adr, delay;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, rd_q;
	logic [15:0] base;
	logic [8:0] avgc, v;
	logic [24:0] acq;
	trac_result_s mres, res_v;
	int seed, mismatches, check_count, cycles, starts, aborts, s0;

	trac_ctrl trac_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .trigger_i(trig),
		.base_interval_i(base), .meas_done_i(done), .meas_result_i(mres), .meas_start_o(start),
		.meas_abort_o(abort), .meas_avg_count_o(avgc), .acq_cycles_o(acq),
		.conductance_susceptance_format_o(fgb), .parallel_cap_conductance_format_o(fcpg));
	trac_meas_engine trac_meas_engine_inst (.clk_i(clk_i), .rst_i(rst_i), .start_i(start), .abort_i(abort),
		.delay_i(delay), .result_i(res_v), .done_o(done), .result_o(mres));

	always #4 clk_i = ~clk_i;

	always @(posedge clk_i) begin
		cycles++;
		if (start === 1'b1) begin
			starts++;
		end
		if (abort === 1'b1) begin
			aborts++;
		end
		if (cycles == 20000) begin
			mismatches++;
			conclude();
		end
	end

	task automatic conclude;
		begin
			if (mismatches == 0 && check_count > 0) begin
				$display("RESULT: PASS");
			end else begin
				$display("RESULT: FAIL");
			end
			$finish;
		end
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		begin
			check_count++;
			if (seen !== exp) begin
				mismatches++;
				$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] q);
		begin
			@(posedge clk_i);
			cyc <= 1'b1;
			stb <= 1'b1;
			we <= w;
			adr <= a;
			wdat <= d;
			sel <= s;
			// wait until ack is seen; only the bench's cycle ceiling ends it if ack never comes
			do begin
				@(posedge clk_i);
			end while (ack !== 1'b1);
			q = rdat;
			cyc <= 1'b0;
			stb <= 1'b0;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		begin
			wb(1'b1, a, d, 4'hF, q);
		end
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		begin
			wb(1'b0, a, 32'h0000_0000, 4'hF, q);
			chk(q, exp);
		end
	endtask

	// one-cycle hardware trigger with a fresh result queued in the engine
	task automatic trig_pulse(input logic [7:0] dly);
		begin
			@(posedge clk_i);
			res_v <= 58'({$random(seed), $random(seed)});
			delay <= dly;
			trig <= 1'b1;
			@(posedge clk_i);
			trig <= 1'b0;
		end
	endtask

	task automatic meas(input logic [7:0] dly);
		begin
			trig_pulse(dly);
			do begin
				@(posedge clk_i);
			end while (done !== 1'b1);
			@(posedge clk_i);
		end
	endtask

	function automatic logic [24:0] acq_exp(input logic [8:0] c, input logic [15:0] b);
		return 25'(c) * 25'(b);
	endfunction

	initial begin
		seed = 76;
		{clk_i, cyc, stb, we, trig, adr, sel, wdat, delay, res_v} = '0;
		{mismatches, check_count, cycles, starts, aborts} = '0;
		base = 16'h0010;
		rst_i = 1'b1;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		rdchk(`TRAC_OFS_CONFIG, 32'h0000_0001);
		rdchk(`TRAC_OFS_AVG_COUNT, 32'h0000_0001);
		rdchk(`TRAC_OFS_STATUS, 32'h0000_0000);
		rdchk(8'h1C, 32'h0000_0000);
		wr(`TRAC_OFS_CMD, 32'h0000_0008);
		rdchk(`TRAC_OFS_CONFIG, 32'h0000_0000);
		wr(`TRAC_OFS_CMD, 32'h0000_0010);
		rdchk(`TRAC_OFS_CONFIG, 32'h0000_0001);
		wr(`TRAC_OFS_CONFIG, 32'h0000_0000);
		// single shot, then a trigger in idle that must be ignored
		wr(`TRAC_OFS_CMD, 32'h0000_0001);
		rdchk(`TRAC_OFS_STATUS, 32'h0000_0001);
		s0 = starts;
		meas(8'h05);
		rdchk(`TRAC_OFS_STATUS, 32'h0000_0008);
		trig_pulse(8'h05);
		repeat (12) @(posedge clk_i);
		chk(32'(starts - s0), 32'h0000_0001);
		wr(`TRAC_OFS_CONFIG, 32'h0000_0001);
		wr(`TRAC_OFS_CMD, 32'h0000_0001);
		meas(8'h03);
		rdchk(`TRAC_OFS_STATUS, 32'h0000_0009);
		// read query aborts a running measurement and blocks commands
		s0 = aborts;
		trig_pulse(8'hC8);
		wr(`TRAC_OFS_CMD, 32'h0000_0002);
		rdchk(`TRAC_OFS_STATUS, 32'h0000_0005);
		chk(32'(aborts - s0), 32'h0000_0001);
		s0 = starts;
		wr(`TRAC_OFS_CMD, 32'h0000_0020);
		wr(`TRAC_OFS_CONFIG, 32'h0000_0000);
		rdchk(`TRAC_OFS_STATUS, 32'h0000_0005);
		rdchk(`TRAC_OFS_CONFIG, 32'h0000_0001);
		chk(32'(starts - s0), 32'h0000_0000);
		meas(8'h04);
		rdchk(`TRAC_OFS_STATUS, 32'h0000_0009);
		rdchk(`TRAC_OFS_RES_PRI, res_v.primary);
		rdchk(`TRAC_OFS_RES_SEC, res_v.secondary);
		rdchk(`TRAC_OFS_RES_STAT, {1'b1, 7'h00, res_v.extra, 6'h00, res_v.extra_kind, res_v.status});
		rdchk(`TRAC_OFS_STATUS, 32'h0000_0001);
		// device clear releases a blocked read, also from idle
		wr(`TRAC_OFS_CMD, 32'h0000_0002);
		wr(`TRAC_OFS_CMD, 32'h0000_0004);
		rdchk(`TRAC_OFS_STATUS, 32'h0000_0000);
		wr(`TRAC_OFS_CMD, 32'h0000_0002);
		rdchk(`TRAC_OFS_STATUS, 32'h0000_0005);
		wr(`TRAC_OFS_CMD, 32'h0000_0004);
		// averaging count, corners first
		wr(`TRAC_OFS_CONFIG, 32'h0000_0002);
		for (int i = 0; i < 8; i++) begin
			v = (i == 0) ? 9'h001 : (i == 1) ? 9'h100 : 9'(($random(seed) & 32'h0000_00FF) + 1);
			wr(`TRAC_OFS_AVG_COUNT, 32'(v));
			base <= 16'($random(seed));
			rdchk(`TRAC_OFS_AVG_COUNT, 32'(v));
			chk(32'(avgc), 32'(v));
			chk(32'(acq), 32'(acq_exp(v, base)));
		end
		wr(`TRAC_OFS_AVG_COUNT, 32'h0000_0000);
		wr(`TRAC_OFS_AVG_COUNT, 32'h0000_0101);
		rdchk(`TRAC_OFS_AVG_COUNT, 32'(v));
		wr(`TRAC_OFS_AVG_COUNT, 32'h0000_0200);
		rdchk(`TRAC_OFS_AVG_COUNT, 32'h0000_0001);
		wr(`TRAC_OFS_AVG_COUNT, 32'h0000_0400);
		rdchk(`TRAC_OFS_AVG_COUNT, 32'h0000_0100);
		wr(`TRAC_OFS_CONFIG, 32'h0000_0000);
		@(posedge clk_i);
		chk(32'(avgc), 32'h0000_0001);
		wr(`TRAC_OFS_AVG_COUNT, 32'h8000_0005);
		rdchk(`TRAC_OFS_CONFIG, 32'h0000_0002);
		wr(`TRAC_OFS_AVG_COUNT, 32'h8000_0001);
		rdchk(`TRAC_OFS_CONFIG, 32'h0000_0000);
		// open-correction format, with a write lacking byte enables
		wr(`TRAC_OFS_CONFIG, 32'h0000_0004);
		rdchk(`TRAC_OFS_CONFIG, 32'h0000_0004);
		chk(32'({fgb, fcpg}), 32'h0000_0001);
		wb(1'b1, `TRAC_OFS_CONFIG, 32'h0000_0000, 4'h0, rd_q);
		rdchk(`TRAC_OFS_CONFIG, 32'h0000_0004);
		wr(`TRAC_OFS_CONFIG, 32'h0000_0000);
		@(posedge clk_i);
		chk(32'({fgb, fcpg}), 32'h0000_0002);
		conclude();
	end
endmodule

`default_nettype wire
